// ===== ffc_corrector.sv
// Our own choices: the placing of the registers and the APB register port.
module ffc_corrector #(
  parameter int X_BITS = 6,
  parameter int Y_BITS = 6,
  parameter int GRID_BITS = 2,
  parameter logic [15:0] TRIM_GAIN = ffc_pkg::TRIM_UNITY
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sensor pixel stream
  input wire logic s_valid_i,
  output logic s_ready_o,
  input wire logic [ffc_pkg::PIX_W-1:0] s_data_i,
  input wire logic s_sof_i,
  // Corrected pixel stream
  output logic m_valid_o,
  input wire logic m_ready_i,
  output logic [ffc_pkg::PIX_W-1:0] m_data_o,
  output logic m_sof_o
);
  import ffc_pkg::*;

  localparam int CSX = X_BITS - GRID_BITS;
  localparam int CSY = Y_BITS - GRID_BITS;
  localparam int ACC_W = PIX_W + CSX + CSY;
  localparam int TOT_W = PIX_W + X_BITS + Y_BITS;
  localparam int IDX_W = 2 + 2 * GRID_BITS;
  localparam int NODES = 1 << IDX_W;
  localparam int CPS_W = PIX_W + IDX_W;

  typedef struct packed {
    logic shading_fix_enable;
    logic target_source_select;
    logic bayer;
    logic [1:0] fmt;
    logic [11:0] manual_target_value;
    logic [SLOT_W-1:0] calib_slot_select;
    logic [31:0] prdata;
    logic pslverr;
    logic [X_BITS-1:0] x;
    logic [Y_BITS-1:0] y;
    logic armed;
    logic capturing;
    logic fin;
    logic [NODES-1:0][ACC_W-1:0] acc;
    logic [TOT_W-1:0] total;
    logic [NODES-1:0][PIX_W-1:0] ref_tbl;
    logic tbl_valid;
    logic [PIX_W-1:0] auto_level;
    ffc_copy_state_type cp;
    logic [IDX_W-1:0] cp_idx;
    logic [CPS_W-1:0] cp_sum;
    ffc_px_state_type px;
    logic [23:0] num;
    logic [11:0] den;
    logic [23:0] quo;
    logic [11:0] rem;
    logic [4:0] iter;
    logic [11:0] res;
    logic res_sof;
  } ffc_state_type;

  ffc_state_type cur;
  ffc_state_type next_cur;
  logic [PIX_W-1:0] nv_mem [NUM_SLOTS*NODES];
  logic [PIX_W-1:0] nv_rd;
  logic [SLOT_W+IDX_W-1:0] nv_addr;

  ffc_stream_if #(.W(PIX_W)) pipe_s();
  ffc_stream_if #(.W(PIX_W)) out_s();

  logic apb_setup;
  logic apb_write;
  logic accept;
  logic [11:0] raw12;
  logic [27:0] trim_prod;
  logic [19:0] trim_sh;
  logic [11:0] raw_t;
  logic [X_BITS-1:0] px_x;
  logic [Y_BITS-1:0] px_y;
  logic [1:0] plane;
  logic [GRID_BITS-1:0] cx;
  logic [GRID_BITS-1:0] cy;
  logic [GRID_BITS-1:0] cx1;
  logic [GRID_BITS-1:0] cy1;
  logic [11:0] node_a;
  logic [11:0] node_b;
  logic [11:0] node_c;
  logic [11:0] node_d;
  logic [11:0] row_top;
  logic [11:0] row_bot;
  logic [11:0] ref_px;
  logic [11:0] target;
  logic [12:0] rem_sh;
  logic q_bit;
  logic [23:0] quo_nx;
  logic [11:0] res_fmt;
  logic frame_end;

  assign apb_setup = psel_i && !penable_i;
  assign apb_write = psel_i && penable_i && pwrite_i;
  assign pready_o = 1'b1;
  assign prdata_o = cur.prdata;
  assign pslverr_o = cur.pslverr;

  // Input scaled to 12-bit working scale, then trimmed
  always_comb begin
    if (cur.fmt == FMT_8) begin
      raw12 = {s_data_i[7:0], 4'h0};
    end else if (cur.fmt == FMT_10) begin
      raw12 = {s_data_i[9:0], 2'h0};
    end else begin
      raw12 = s_data_i;
    end
  end
  assign trim_prod = 28'(raw12) * 28'(TRIM_GAIN);
  assign trim_sh = trim_prod[27:TRIM_FRAC];
  assign raw_t = (trim_sh > 20'(PIX_MAX)) ? PIX_MAX : trim_sh[11:0];

  // Pixel position and grid lookup
  assign px_x = s_sof_i ? '0 : cur.x;
  assign px_y = s_sof_i ? '0 : cur.y;
  assign plane = cur.bayer ? {px_y[0], px_x[0]} : 2'h0;
  assign cx = px_x[X_BITS-1:CSX];
  assign cy = px_y[Y_BITS-1:CSY];
  assign cx1 = (&cx) ? cx : cx + 1'b1;
  assign cy1 = (&cy) ? cy : cy + 1'b1;
  assign node_a = cur.ref_tbl[{plane, cy, cx}];
  assign node_b = cur.ref_tbl[{plane, cy, cx1}];
  assign node_c = cur.ref_tbl[{plane, cy1, cx}];
  assign node_d = cur.ref_tbl[{plane, cy1, cx1}];

  // Bilinear expansion of the reduced table
  ffc_lerp #(.W(PIX_W), .F(CSX)) u_lerp_top (
    .a_i(node_a),
    .b_i(node_b),
    .f_i(px_x[CSX-1:0]),
    .y_o(row_top)
  );
  ffc_lerp #(.W(PIX_W), .F(CSX)) u_lerp_bot (
    .a_i(node_c),
    .b_i(node_d),
    .f_i(px_x[CSX-1:0]),
    .y_o(row_bot)
  );
  ffc_lerp #(.W(PIX_W), .F(CSY)) u_lerp_vert (
    .a_i(row_top),
    .b_i(row_bot),
    .f_i(px_y[CSY-1:0]),
    .y_o(ref_px)
  );

  assign target = cur.target_source_select ? cur.auto_level : cur.manual_target_value;
  assign s_ready_o = (cur.px == PX_IDLE) && (cur.cp == CP_IDLE);
  assign accept = s_valid_i && s_ready_o;
  assign frame_end = (&px_x) && (&px_y);

  // One restoring divider step
  assign rem_sh = {cur.rem, cur.num[23]};
  assign q_bit = (rem_sh >= {1'b0, cur.den});
  assign quo_nx = {cur.quo[22:0], q_bit};

  always_comb begin
    if (cur.fmt == FMT_8) begin
      res_fmt = {4'h0, cur.res[11:4]};
    end else if (cur.fmt == FMT_10) begin
      res_fmt = {2'h0, cur.res[11:2]};
    end else begin
      res_fmt = cur.res;
    end
  end
  assign pipe_s.valid = (cur.px == PX_PUSH);
  assign pipe_s.data = res_fmt;
  assign pipe_s.sof = cur.res_sof;

  ffc_skid #(.W(PIX_W)) u_skid (
    .clk_sys_i(clk_sys_i),
    .rst_b_i(rst_b_i),
    .in_s(pipe_s.dst),
    .out_s(out_s.src)
  );
  assign m_valid_o = out_s.valid;
  assign m_data_o = out_s.data;
  assign m_sof_o = out_s.sof;
  assign out_s.ready = m_ready_i;

  // Non-volatile slot memory, never reset
  assign nv_addr = {cur.calib_slot_select, cur.cp_idx};
  assign nv_rd = nv_mem[nv_addr];
  always_ff @(posedge clk_sys_i) begin
    if (cur.cp == CP_STORE) begin
      nv_mem[nv_addr] <= cur.ref_tbl[cur.cp_idx];
    end
  end

  always_comb begin
    next_cur = cur;
    // Register reads, answered in the access phase
    if (apb_setup) begin
      next_cur.prdata = '0;
      next_cur.pslverr = 1'b0;
      if (paddr_i == ADDR_CTRL) begin
        next_cur.prdata[CTRL_EN_BIT] = cur.shading_fix_enable;
        next_cur.prdata[CTRL_AUTO_BIT] = cur.target_source_select;
        next_cur.prdata[CTRL_BAYER_BIT] = cur.bayer;
        next_cur.prdata[CTRL_FMT_LSB+:2] = cur.fmt;
      end else if (paddr_i == ADDR_TARGET) begin
        next_cur.prdata[11:0] = cur.manual_target_value;
      end else if (paddr_i == ADDR_SLOT) begin
        next_cur.prdata[SLOT_W-1:0] = cur.calib_slot_select;
      end else if (paddr_i == ADDR_CMD) begin
        next_cur.prdata = '0;
      end else if (paddr_i == ADDR_STATUS) begin
        next_cur.prdata[ST_ARMED_BIT] = cur.armed;
        next_cur.prdata[ST_CAPTURING_BIT] = cur.capturing || cur.fin;
        next_cur.prdata[ST_COPY_BIT] = (cur.cp != CP_IDLE);
        next_cur.prdata[ST_VALID_BIT] = cur.tbl_valid;
        next_cur.prdata[ST_AUTO_LSB+:PIX_W] = cur.auto_level;
      end else begin
        next_cur.pslverr = 1'b1;
      end
    end

    // Finish capture: reduce sums to cell averages
    if (cur.fin) begin
      for (int i = 0; i < NODES; i++) begin
        if (cur.bayer) begin
          next_cur.ref_tbl[i] = cur.acc[i][PIX_W+CSX+CSY-3:CSX+CSY-2];
        end else begin
          next_cur.ref_tbl[i] = cur.acc[i % (NODES / 4)][ACC_W-1:CSX+CSY];
        end
      end
      next_cur.auto_level = (cur.total[TOT_W-1:X_BITS+Y_BITS] == '0) ? TARGET_MIN :
                            cur.total[TOT_W-1:X_BITS+Y_BITS];
      next_cur.tbl_valid = 1'b1;
      next_cur.fin = 1'b0;
    end

    // Slot copy engine, one word a cycle
    if (cur.cp != CP_IDLE) begin
      if (cur.cp == CP_RESTORE) begin
        next_cur.ref_tbl[cur.cp_idx] = nv_rd;
        next_cur.cp_sum = cur.cp_sum + CPS_W'(nv_rd);
      end
      next_cur.cp_idx = cur.cp_idx + 1'b1;
      if (&cur.cp_idx) begin
        if (cur.cp == CP_RESTORE) begin
          next_cur.auto_level = (next_cur.cp_sum[CPS_W-1:IDX_W] == '0) ? TARGET_MIN :
                                next_cur.cp_sum[CPS_W-1:IDX_W];
          next_cur.tbl_valid = 1'b1;
        end
        next_cur.cp = CP_IDLE;
      end
    end

    // Pixel path
    case (cur.px)
      PX_IDLE: begin
        if (accept) begin
          next_cur.x = px_x + 1'b1;
          next_cur.y = (&px_x) ? px_y + 1'b1 : px_y;
          next_cur.num = 24'(raw_t) * 24'(target);
          next_cur.den = ref_px;
          next_cur.res = raw_t;
          next_cur.res_sof = s_sof_i;
          next_cur.quo = '0;
          next_cur.rem = '0;
          next_cur.iter = '0;
          if (cur.shading_fix_enable && (ref_px != '0)) begin
            next_cur.px = PX_DIV;
          end else begin
            next_cur.px = PX_PUSH;
          end
          // Capture accumulation over one whole frame
          if (cur.capturing || (cur.armed && s_sof_i)) begin
            if (s_sof_i) begin
              next_cur.acc = '0;
              next_cur.total = '0;
              next_cur.armed = 1'b0;
              next_cur.capturing = 1'b1;
            end
            next_cur.acc[{plane, cy, cx}] = next_cur.acc[{plane, cy, cx}] + ACC_W'(raw_t);
            next_cur.total = next_cur.total + TOT_W'(raw_t);
            if (frame_end) begin
              next_cur.capturing = 1'b0;
              next_cur.fin = 1'b1;
            end
          end
        end
      end
      PX_DIV: begin
        next_cur.rem = q_bit ? 12'(rem_sh - {1'b0, cur.den}) : rem_sh[11:0];
        next_cur.quo = quo_nx;
        next_cur.num = {cur.num[22:0], 1'b0};
        next_cur.iter = cur.iter + 1'b1;
        if (cur.iter == DIV_LAST) begin
          next_cur.res = (quo_nx > 24'(PIX_MAX)) ? PIX_MAX : quo_nx[11:0];
          next_cur.px = PX_PUSH;
        end
      end
      PX_PUSH: begin
        if (pipe_s.ready) begin
          next_cur.px = PX_IDLE;
        end
      end
      default: begin
        next_cur.px = PX_IDLE;
      end
    endcase

    // Register writes at the access edge
    if (apb_write) begin
      if (paddr_i == ADDR_CTRL) begin
        next_cur.shading_fix_enable = pwdata_i[CTRL_EN_BIT];
        next_cur.target_source_select = pwdata_i[CTRL_AUTO_BIT];
        next_cur.bayer = pwdata_i[CTRL_BAYER_BIT];
        next_cur.fmt = (pwdata_i[CTRL_FMT_LSB+:2] > FMT_12) ? FMT_12 : pwdata_i[CTRL_FMT_LSB+:2];
      end else if (paddr_i == ADDR_TARGET) begin
        next_cur.manual_target_value = (pwdata_i[11:0] == '0) ? TARGET_MIN : pwdata_i[11:0];
      end else if (paddr_i == ADDR_SLOT) begin
        next_cur.calib_slot_select = pwdata_i[SLOT_W-1:0];
      end else if (paddr_i == ADDR_CMD && cur.cp == CP_IDLE) begin
        if (pwdata_i[CMD_STORE_BIT] && !cur.capturing && !cur.fin) begin
          next_cur.cp = CP_STORE;
          next_cur.cp_idx = '0;
        end else if (pwdata_i[CMD_RESTORE_BIT] && !cur.fin) begin
          next_cur.cp = CP_RESTORE;
          next_cur.cp_idx = '0;
          next_cur.cp_sum = '0;
          next_cur.armed = 1'b0;
          next_cur.capturing = 1'b0;
        end else if (pwdata_i[CMD_CAPTURE_BIT]) begin
          next_cur.armed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cur <= '0;
      cur.fmt <= FMT_RESET;
      cur.manual_target_value <= TARGET_RESET;
      cur.calib_slot_select <= SLOT_RESET;
      cur.auto_level <= TARGET_RESET;
      cur.cp <= CP_IDLE;
      cur.px <= PX_IDLE;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : ffc_corrector

// ===== ffc_corrector_assertions.sv
module ffc_corrector_assertions (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Pixel streams
  input wire logic s_valid_i,
  input wire logic s_ready_o,
  input wire logic [ffc_pkg::PIX_W-1:0] s_data_i,
  input wire logic m_valid_o,
  input wire logic m_ready_i,
  input wire logic [ffc_pkg::PIX_W-1:0] m_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ffc_pkg::*;
  logic en_q;
  logic [1:0] fmt_q;
  logic [11:0] tgt_q;
  logic wr_s;
  logic acc;
  assign wr_s = psel_i && penable_i && pwrite_i;
  assign acc = s_valid_i && s_ready_o;
  // Shadow of the written settings
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      en_q <= 1'b0;
      fmt_q <= FMT_RESET;
      tgt_q <= TARGET_RESET;
    end else if (wr_s && paddr_i == ADDR_CTRL) begin
      en_q <= pwdata_i[CTRL_EN_BIT];
      fmt_q <= (pwdata_i[5:4] > FMT_12) ? FMT_12 : pwdata_i[5:4];
    end else if (wr_s && paddr_i == ADDR_TARGET) begin
      tgt_q <= (pwdata_i[11:0] == 12'h000) ? TARGET_MIN : pwdata_i[11:0];
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  sequence setup_s(logic [7:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence
  sequence cmd_s(int b);
    wr_s && paddr_i == ADDR_CMD && pwdata_i[b];
  endsequence
  sequence stall_s;
    !s_ready_o [*8];
  endsequence
  ctrl_read_a: assert property (setup_s(ADDR_CTRL) |=>
    prdata_o[CTRL_EN_BIT] == en_q && prdata_o[5:4] == fmt_q) else $error("ctrl readback wrong");
  target_read_a: assert property (setup_s(ADDR_TARGET) |=> prdata_o[11:0] == tgt_q)
    else $error("target readback wrong");
  pass_lat_a: assert property (acc && !en_q && !m_valid_o |->
    ##2 m_valid_o && m_data_o == $past(s_data_i, 2)) else $error("bypass pixel wrong");
  fmt_clamp_a: assert property (m_valid_o && fmt_q != FMT_12 |->
    m_data_o[11:10] == 2'h0 && (fmt_q != FMT_8 || m_data_o[9:8] == 2'h0)) else $error("pixel above format");
  one_pixel_a: assert property (acc |=> !s_ready_o) else $error("second pixel taken");
  out_hold_a: assert property (m_valid_o && !m_ready_i |=>
    m_valid_o && $stable(m_data_o)) else $error("stalled output changed");
  restore_stall_a: assert property (cmd_s(CMD_RESTORE_BIT) and !pwdata_i[CMD_STORE_BIT] |->
    ##[1:2] stall_s) else $error("restore did not stall input");
  store_stall_a: assert property (cmd_s(CMD_STORE_BIT) |-> ##[1:2] stall_s)
    else $error("store did not stall input");
  bad_addr_a: assert property (psel_i && !penable_i && (paddr_i > ADDR_STATUS || paddr_i[1:0] != 2'h0)
    |=> pslverr_o && prdata_o == 32'h0) else $error("unmapped access not flagged");
  access_ready_a: assert property (psel_i && penable_i |-> pready_o) else $error("access phase not answered");
endmodule : ffc_corrector_assertions

bind ffc_corrector ffc_corrector_assertions i_ffc_corrector_assertions (
  .clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
  .pslverr_o, .s_valid_i, .s_ready_o, .s_data_i, .m_valid_o, .m_ready_i, .m_data_o
);

// ===== ffc_corrector_tb.sv
module ffc_corrector_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ffc_pkg::*;
  localparam int NPIX = 64;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, s_valid_i, s_ready_o, s_sof_i, m_valid_o, m_sof_o;
  logic m_ready_i = 1'b1;
  logic stall = 1'b0;
  logic [PIX_W-1:0] s_data_i, m_data_o;
  logic [PIX_W-1:0] outq[$];
  logic sofq[$];
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  initial forever #12.5 clk_sys_i = ~clk_sys_i;
  ffc_corrector #(.X_BITS(3), .Y_BITS(3), .GRID_BITS(2)) i_ffc_corrector (
    .clk_sys_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .s_valid_i, .s_ready_o, .s_data_i, .s_sof_i, .m_valid_o, .m_ready_i, .m_data_o, .m_sof_o
  );
  ffc_sensor_model #(.X_BITS(3), .Y_BITS(3)) i_ffc_sensor_model (
    .clk_sys_i, .s_ready_i(s_ready_o), .s_valid_o(s_valid_i), .s_data_o(s_data_i), .s_sof_o(s_sof_i)
  );
  // Host sink, ready only one cycle in sixteen while stalling
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    m_ready_i <= !stall || (cyc[3:0] == 4'h0);
    if (m_valid_o && m_ready_i) begin
      outq.push_back(m_data_o);
      sofq.push_back(m_sof_o);
    end
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i iff pready_o);
    r = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    cmp(r, exp);
    cmp({31'h0, e}, {31'h0, xe});
  endtask : rdc
  // Copy between table and slot takes 64 cycles
  task automatic cpy(input logic [31:0] c);
    wr(ADDR_CMD, c);
    repeat (66) @(posedge clk_sys_i);
  endtask : cpy
  task automatic frame(input logic [3:0][PIX_W-1:0] pv, input logic [3:0][PIX_W-1:0] ev);
    int n;
    n = 0;
    outq.delete();
    sofq.delete();
    i_ffc_sensor_model.send_frame(pv);
    while (outq.size() < NPIX && n < 4000) begin
      @(posedge clk_sys_i);
      n++;
    end
    for (int i = 0; i < NPIX; i++) begin
      cmp({20'h0, outq[i]}, {20'h0, ev[{i[3], i[0]}]});
    end
    cmp({30'h0, sofq[0], sofq[1]}, 32'h2);
  endtask : frame
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  initial begin
    logic [3:0][PIX_W-1:0] pv;
    int s;
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdc(ADDR_CTRL, 32'h20, 1'b0);
    rdc(ADDR_TARGET, 32'h800, 1'b0);
    rdc(ADDR_SLOT, 32'h0, 1'b0);
    rdc(ADDR_CMD, 32'h0, 1'b0);
    rdc(ADDR_STATUS, 32'h0800_0000, 1'b0);
    wr(8'h14, 32'h21);
    rdc(8'h14, 32'h0, 1'b1);
    rdc(ADDR_CTRL, 32'h20, 1'b0);
    $display("test registers done");
    stall = 1'b1;
    frame(48'h7ff_000_fff_123, 48'h7ff_000_fff_123);
    stall = 1'b0;
    wr(ADDR_CTRL, 32'h21);
    frame(48'h7ff_000_fff_123, 48'h7ff_000_fff_123);
    $display("test bypass done");
    wr(ADDR_CMD, 32'h1);
    rdc(ADDR_STATUS, 32'h0800_0001, 1'b0);
    frame(48'h400_400_400_400, 48'h400_400_400_400);
    rdc(ADDR_STATUS, 32'h0400_0008, 1'b0);
    $display("test capture done");
    for (int f = 0; f < 3; f++) begin
      s = (f == 0) ? 4 : (f == 1) ? 2 : 0;
      wr(ADDR_CTRL, 32'h1 | (f << 4));
      pv = {12'h0, 12'h400 >> s, 12'hc00 >> s, 12'h200 >> s};
      frame(pv, {12'h0, 12'h800 >> s, 12'hfff >> s, 12'h400 >> s});
    end
    wr(ADDR_CTRL, 32'h31);
    rdc(ADDR_CTRL, 32'h21, 1'b0);
    wr(ADDR_TARGET, 32'h0);
    rdc(ADDR_TARGET, 32'h1, 1'b0);
    wr(ADDR_CTRL, 32'h23);
    frame(48'h100_300_200_400, 48'h100_300_200_400);
    $display("test target done");
    wr(ADDR_CTRL, 32'h21);
    wr(ADDR_TARGET, 32'h800);
    wr(ADDR_SLOT, 32'h5);
    rdc(ADDR_SLOT, 32'h5, 1'b0);
    cpy(32'h2);
    wr(ADDR_CMD, 32'h1);
    frame(48'h200_200_200_200, 48'h400_400_400_400);
    rdc(ADDR_STATUS, 32'h0200_0008, 1'b0);
    cpy(32'h4);
    rdc(ADDR_STATUS, 32'h0400_0008, 1'b0);
    frame(48'h200_200_200_200, 48'h400_400_400_400);
    $display("test slots done");
    wr(ADDR_CTRL, 32'h25);
    wr(ADDR_CMD, 32'h1);
    frame(48'h400_300_200_100, 48'h800_600_400_200);
    frame(48'h400_300_200_100, 48'h800_800_800_800);
    $display("test bayer done");
    rst_b_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rdc(ADDR_STATUS, 32'h0800_0000, 1'b0);
    wr(ADDR_CTRL, 32'h21);
    frame(48'h7ff_000_fff_123, 48'h7ff_000_fff_123);
    wr(ADDR_SLOT, 32'h5);
    cpy(32'h4);
    rdc(ADDR_STATUS, 32'h0400_0008, 1'b0);
    frame(48'h200_200_200_200, 48'h400_400_400_400);
    $display("test reset done");
    conclude();
  end
endmodule : ffc_corrector_tb

// ===== ffc_lerp.sv
module ffc_lerp #(
  parameter int W = 12,
  parameter int F = 4
) (
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  input wire logic [F-1:0] f_i,
  output logic [W-1:0] y_o
);
  localparam logic [F:0] ONE = {1'b1, {F{1'b0}}};
  logic [F:0] wa;
  logic [W+F:0] pa;
  logic [W+F:0] pb;
  logic [W+F:0] sum;
  // Weighted mix of two neighbouring nodes
  assign wa = ONE - {1'b0, f_i};
  assign pa = (W+F+1)'(a_i) * (W+F+1)'(wa);
  assign pb = (W+F+1)'(b_i) * (W+F+1)'(f_i);
  assign sum = pa + pb;
  assign y_o = sum[W+F-1:F];
endmodule : ffc_lerp

// ===== ffc_pkg.sv
// Summary of operation
// - Corrected level equals raw level times target, divided by reference level.
// - Reference data is applied only while shading_fix_enable is on.
// - Automatic target source derives the target level from reference data.
// - Manual target source uses manual_target_value, 1 to 4095 on 12-bit scale.
// - After capture command, the next whole frame builds reduced reference data.
// - Captured reference data lives only in volatile working memory.
// - Sixteen non-volatile slots; calib_slot_select picks slot for store and restore.
// - Store command copies active reference data into the selected slot.
// - Restore command copies the selected slot into active reference data.
// - Restore after capture without store discards captured data.
// - Reduced reference data is expanded by bilinear interpolation before use.
// - Bayer formats correct each of the four colour sites independently.
// - Fixed per-pixel response trim coefficients are applied to every pixel; the code applies one fixed gain, TRIM_GAIN, to all pixels.
package ffc_pkg;
  localparam int PIX_W = 12;
  localparam logic [11:0] PIX_MAX = 12'hfff;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_SLOT = 8'h08;
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_BAYER_BIT = 2;
  localparam int CTRL_FMT_LSB = 4;
  localparam int CMD_CAPTURE_BIT = 0;
  localparam int CMD_STORE_BIT = 1;
  localparam int CMD_RESTORE_BIT = 2;
  localparam int ST_ARMED_BIT = 0;
  localparam int ST_CAPTURING_BIT = 1;
  localparam int ST_COPY_BIT = 2;
  localparam int ST_VALID_BIT = 3;
  localparam int ST_AUTO_LSB = 16;
  localparam logic [1:0] FMT_8 = 2'h0;
  localparam logic [1:0] FMT_10 = 2'h1;
  localparam logic [1:0] FMT_12 = 2'h2;
  localparam logic [1:0] FMT_RESET = FMT_12;
  localparam logic [11:0] TARGET_RESET = 12'h800;
  localparam logic [11:0] TARGET_MIN = 12'h001;
  localparam logic [3:0] SLOT_RESET = 4'h0;
  localparam int NUM_SLOTS = 16;
  localparam int SLOT_W = 4;
  localparam int TRIM_FRAC = 8;
  localparam logic [15:0] TRIM_UNITY = 16'h0100;
  localparam int DIV_STEPS = 24;
  localparam logic [4:0] DIV_LAST = 5'h17;
  typedef enum logic [1:0] {PX_IDLE, PX_DIV, PX_PUSH} ffc_px_state_type;
  typedef enum logic [1:0] {CP_IDLE, CP_STORE, CP_RESTORE} ffc_copy_state_type;
endpackage : ffc_pkg

// ===== ffc_sensor_model.sv
module ffc_sensor_model #(
  parameter int X_BITS = 3,
  parameter int Y_BITS = 3
) (
  // Clock
  input wire logic clk_sys_i,
  // Pixel stream toward the corrector
  input wire logic s_ready_i,
  output logic s_valid_o,
  output logic [ffc_pkg::PIX_W-1:0] s_data_o,
  output logic s_sof_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ffc_pkg::*;
  initial begin
    s_valid_o = 1'b0;
    s_data_o = 12'h5a5;
    s_sof_o = 1'b0;
  end
  // Whole frame from origin at full size, one value per colour site
  // Defect-free frame, as if defect correction ran first
  task automatic send_frame(input logic [3:0][PIX_W-1:0] pv);
    int n;
    n = 0;
    while (n < 2 ** (X_BITS + Y_BITS)) begin
      s_valid_o <= 1'b1;
      s_sof_o <= (n == 0);
      s_data_o <= pv[{n[X_BITS], n[0]}];
      @(posedge clk_sys_i iff s_ready_i);
      n++;
    end
    s_valid_o <= 1'b0;
    s_sof_o <= 1'b0;
    s_data_o <= ~s_data_o;
  endtask : send_frame
endmodule : ffc_sensor_model

// ===== ffc_skid.sv
module ffc_skid #(
  parameter int W = 12
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  ffc_stream_if.dst in_s,
  ffc_stream_if.src out_s
);
  typedef struct packed {
    logic [1:0][W:0] ent;
    logic [1:0] cnt;
    logic wp;
    logic rp;
  } ffc_skid_state_type;
  ffc_skid_state_type cur;
  ffc_skid_state_type next_cur;
  logic push;
  logic pop;

  assign in_s.ready = (cur.cnt != 2'h2);
  assign out_s.valid = (cur.cnt != 2'h0);
  assign out_s.data = cur.ent[cur.rp][W-1:0];
  assign out_s.sof = cur.ent[cur.rp][W];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_comb begin
    next_cur = cur;
    if (push) begin
      next_cur.ent[cur.wp] = {in_s.sof, in_s.data};
      next_cur.wp = ~cur.wp;
    end
    if (pop) begin
      next_cur.rp = ~cur.rp;
    end
    if (push && !pop) begin
      next_cur.cnt = cur.cnt + 2'h1;
    end else if (pop && !push) begin
      next_cur.cnt = cur.cnt - 2'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
endmodule : ffc_skid

// ===== ffc_stream_if.sv
interface ffc_stream_if #(parameter int W = 12);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  logic sof;
  modport src(output valid, output data, output sof, input ready);
  modport dst(input valid, input data, input sof, output ready);
endinterface : ffc_stream_if
